// ===== rtl/rxar_pkg.sv
package rxar_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFF_INDEX = 8'h08;
    localparam logic [7:0] OFF_DMA_STATUS = 8'h0C;
    localparam logic [7:0] OFF_TX_HDP_BASE = 8'h40;
    localparam logic [7:0] OFF_RX_HDP_BASE = 8'h60;

    // Address RAM geometry
    localparam int ENTRIES = 32;
    localparam int IDX_W = 5;
    localparam int CHANS = 8;
    localparam int CH_W = 3;

    // Field positions in the low address register
    localparam int BIT_VALID = 20;
    localparam int BIT_ACCEPT = 19;
    localparam int CH_LSB = 16;
    localparam int BYTE0_LSB = 8;
    localparam int BYTE1_LSB = 0;

    // Field positions in the high address register
    localparam int BYTE2_LSB = 24;
    localparam int BYTE3_LSB = 16;
    localparam int BYTE4_LSB = 8;
    localparam int BYTE5_LSB = 0;

    // Reset values
    localparam logic [31:0] HDP_RESET = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // One address RAM entry: 53 bits
    typedef struct packed {
        logic valid;
        logic accept_or_reject_select;
        logic [CH_W-1:0] chan;
        logic [47:0] addr;
    } rxar_entry_t;

    // Wishbone request bundle
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rxar_wb_req_t;

    // Filter lookup result
    typedef struct packed {
        logic hit;
        logic accept;
        logic [CH_W-1:0] chan;
    } rxar_match_t;

endpackage

// ===== rtl/rxar_regs.sv
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/10ps
module rxar_regs #(
    parameter int ENTRIES = rxar_pkg::ENTRIES,
    parameter int CHANS = rxar_pkg::CHANS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Receive filter lookup
    input wire logic lookup_req_i,
    input wire logic [47:0] lookup_addr_i,
    output logic lookup_valid_o,
    output logic lookup_hit_o,
    output logic lookup_accept_o,
    output logic [rxar_pkg::CH_W-1:0] lookup_chan_o,
    // DMA engine side
    output logic [CHANS-1:0] tx_start_o,
    output logic [CHANS-1:0] rx_permit_o,
    output logic [CHANS-1:0][31:0] tx_hdp_o,
    output logic [CHANS-1:0][31:0] rx_hdp_o,
    input wire logic [CHANS-1:0] tx_hdp_clr_i,
    input wire logic [CHANS-1:0] rx_hdp_clr_i
);

    // Overview of behaviour
    // Bus side: one classic cycle per access
    // Request taken when no answer is outstanding
    // Ack or err follows one cycle after taking
    // Ack drops next cycle even with strobe held
    // Unmapped offsets answer with err, no effect
    // Read data registered, zero on writes
    // Entry staging: index and high only stage
    // Low write merges lanes with current entry
    // Commit lands at index on low write edge
    // Index keeps its value across commits
    // Index write needs lane zero enabled
    // Filter side: compare runs every cycle
    // Result registered on a lookup request
    // Result holds until the next request
    // Reject entry beats accept entry on ties
    // Channel from lowest accept entry index
    // Channel forced zero unless accepted
    // DMA side: pointer write pulses start or permit
    // Pulse lasts one cycle after the write edge
    // Engine clear zeroes a pointer at queue end
    // Software write wins over same-cycle clear
    // Nonzero rewrite is not blocked by hardware
    // Status word flags nonzero pointers per channel

    // Hazards
    // Address RAM has no reset value
    // Lookups before full load see unknown entries
    // Partial low writes merge with stale contents
    // Software must load every entry first

    // Register map
    // Low address and control at the base
    // High address bytes one word up
    // Entry index, five bits, next word
    // Pointer status word, read only
    // Transmit pointers, one word per channel
    // Receive pointers, one word per channel
    // Everything else answers with err

    // Low register layout
    // Valid flag above the accept or reject flag
    // Three channel bits below those flags
    // Address byte zero in the second byte lane
    // Address byte one in the lowest byte lane
    // High register: bytes two to five, top down

    // All state of the block except the address RAM
    typedef struct packed {
        logic [rxar_pkg::IDX_W-1:0] index;
        logic [31:0] high;
        logic [CHANS-1:0][31:0] tx_hdp;
        logic [CHANS-1:0][31:0] rx_hdp;
        logic [CHANS-1:0] tx_start;
        logic [CHANS-1:0] rx_permit;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic lk_valid;
        rxar_pkg::rxar_match_t lk;
    } rxar_state_t;

    rxar_state_t s_q;
    rxar_state_t s_d;

    // Address RAM, no reset: software must load it before use
    rxar_pkg::rxar_entry_t ram_q [ENTRIES];
    logic ram_we;
    rxar_pkg::rxar_entry_t ram_wdata;

    // Request bundle
    rxar_pkg::rxar_wb_req_t req;
    logic access;
    logic [31:0] wmask;
    logic [31:0] low_word;
    logic [2:0] ch_sel;
    logic tx_sel;
    logic rx_sel;
    logic known;
    rxar_pkg::rxar_match_t match_c;

    // Gather bus request
    // Access is blocked while an answer is out
    // Keeps a held strobe from being taken twice
    // Byte lane mask built from the select bits
    always_comb begin
        req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                sel: wb_sel_i, dat: wb_dat_i};
        access = req.cyc && req.stb && !s_q.ack && !s_q.err;
        for (int b = 0; b < 4; b++) begin
            wmask[b*8 +: 8] = {8{req.sel[b]}};
        end
    end

    // Decode pointer windows
    // Upper address bits pick the pointer window
    // Word offset inside a window is the channel
    // Channels past the parameter are unmapped
    // Known offsets get ack, the rest get err
    always_comb begin
        ch_sel = req.adr[4:2];
        tx_sel = (req.adr[7:5] == rxar_pkg::OFF_TX_HDP_BASE[7:5]) &&
                 (32'(ch_sel) < CHANS);
        rx_sel = (req.adr[7:5] == rxar_pkg::OFF_RX_HDP_BASE[7:5]) &&
                 (32'(ch_sel) < CHANS);
        known = tx_sel || rx_sel ||
                req.adr == rxar_pkg::OFF_ADDR_LOW ||
                req.adr == rxar_pkg::OFF_ADDR_HIGH ||
                req.adr == rxar_pkg::OFF_INDEX ||
                req.adr == rxar_pkg::OFF_DMA_STATUS;
    end

    // Low register image of the entry at the current index
    // Serves both read back and lane merging
    // Reserved upper bits stay zero
    always_comb begin
        rxar_pkg::rxar_entry_t e;
        e = ram_q[s_q.index];
        low_word = rxar_pkg::ZERO_WORD;
        low_word[rxar_pkg::BIT_VALID] = e.valid;
        low_word[rxar_pkg::BIT_ACCEPT] = e.accept_or_reject_select;
        low_word[rxar_pkg::CH_LSB +: rxar_pkg::CH_W] = e.chan;
        low_word[rxar_pkg::BYTE0_LSB +: 8] = e.addr[7:0];
        low_word[rxar_pkg::BYTE1_LSB +: 8] = e.addr[15:8];
    end

    // Commit path: only a low register write writes the RAM
    // Unselected lanes keep the stored entry bits
    // Upper address comes from the staged high word
    // Index and high writes never touch the RAM
    always_comb begin
        logic [31:0] lw;
        lw = (low_word & ~wmask) | (req.dat & wmask);
        ram_we = access && req.we && req.adr == rxar_pkg::OFF_ADDR_LOW;
        ram_wdata.valid = lw[rxar_pkg::BIT_VALID];
        ram_wdata.accept_or_reject_select = lw[rxar_pkg::BIT_ACCEPT];
        ram_wdata.chan = lw[rxar_pkg::CH_LSB +: rxar_pkg::CH_W];
        ram_wdata.addr = {s_q.high[rxar_pkg::BYTE5_LSB +: 8],
                          s_q.high[rxar_pkg::BYTE4_LSB +: 8],
                          s_q.high[rxar_pkg::BYTE3_LSB +: 8],
                          s_q.high[rxar_pkg::BYTE2_LSB +: 8],
                          lw[rxar_pkg::BYTE1_LSB +: 8],
                          lw[rxar_pkg::BYTE0_LSB +: 8]};
    end

    // Filter compare over every entry
    // Walks from the top so the lowest index wins
    // Any reject entry on the address vetoes accept
    // Invalid entries are skipped whatever they hold
    // Wide compare, one level of logic per entry
    always_comb begin
        logic rej;
        logic acc;
        logic [rxar_pkg::CH_W-1:0] ch;
        rej = 1'b0;
        acc = 1'b0;
        ch = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            // Skip invalid entries entirely
            if (ram_q[i].valid && ram_q[i].addr == lookup_addr_i) begin
                if (ram_q[i].accept_or_reject_select) begin
                    acc = 1'b1;
                    ch = ram_q[i].chan;
                end else begin
                    rej = 1'b1;
                end
            end
        end
        match_c.hit = acc || rej;
        match_c.accept = acc && !rej;
        match_c.chan = (acc && !rej) ? ch : '0;
    end

    // Next state
    // Pulses default low and last one cycle
    // Lookup result captured only on a request
    // Engine clears come first so writes win
    // Read data cleared on every taken access
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.tx_start = '0;
        s_d.rx_permit = '0;
        s_d.lk_valid = lookup_req_i;
        if (lookup_req_i) begin
            s_d.lk = match_c;
        end
        // Engine clears a pointer at end of queue
        for (int c = 0; c < CHANS; c++) begin
            if (tx_hdp_clr_i[c]) begin
                s_d.tx_hdp[c] = rxar_pkg::HDP_RESET;
            end
            if (rx_hdp_clr_i[c]) begin
                s_d.rx_hdp[c] = rxar_pkg::HDP_RESET;
            end
        end
        if (access) begin
            s_d.ack = known;
            s_d.err = !known;
            s_d.rdata = rxar_pkg::ZERO_WORD;
            if (req.we) begin
                // Staging and pointer writes; software write wins over engine clear
                if (req.adr == rxar_pkg::OFF_ADDR_HIGH) begin
                    s_d.high = (s_q.high & ~wmask) | (req.dat & wmask);
                end else if (req.adr == rxar_pkg::OFF_INDEX) begin
                    if (req.sel[0]) begin
                        s_d.index = req.dat[rxar_pkg::IDX_W-1:0];
                    end
                end else if (tx_sel) begin
                    s_d.tx_hdp[ch_sel] = (s_q.tx_hdp[ch_sel] & ~wmask) | (req.dat & wmask);
                    s_d.tx_start[ch_sel] = 1'b1;
                end else if (rx_sel) begin
                    s_d.rx_hdp[ch_sel] = (s_q.rx_hdp[ch_sel] & ~wmask) | (req.dat & wmask);
                    s_d.rx_permit[ch_sel] = 1'b1;
                end
            end else begin
                // Read mux; reserved bits read zero
                if (req.adr == rxar_pkg::OFF_ADDR_LOW) begin
                    s_d.rdata = low_word;
                end else if (req.adr == rxar_pkg::OFF_ADDR_HIGH) begin
                    s_d.rdata = s_q.high;
                end else if (req.adr == rxar_pkg::OFF_INDEX) begin
                    s_d.rdata[rxar_pkg::IDX_W-1:0] = s_q.index;
                end else if (req.adr == rxar_pkg::OFF_DMA_STATUS) begin
                    for (int c = 0; c < CHANS; c++) begin
                        s_d.rdata[c] = |s_q.tx_hdp[c];
                        s_d.rdata[c + 16] = |s_q.rx_hdp[c];
                    end
                end else if (tx_sel) begin
                    s_d.rdata = s_q.tx_hdp[ch_sel];
                end else if (rx_sel) begin
                    s_d.rdata = s_q.rx_hdp[ch_sel];
                end
            end
        end
    end

    // State register
    // Synchronous reset clears all but the RAM
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Address RAM write
    // No reset: contents unknown until loaded
    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            ram_q[s_q.index] <= ram_wdata;
        end
    end

    // Outputs
    // Every output comes straight from a flop
    assign wb_ack_o = s_q.ack;
    assign wb_err_o = s_q.err;
    assign wb_dat_o = s_q.rdata;
    assign lookup_valid_o = s_q.lk_valid;
    assign lookup_hit_o = s_q.lk.hit;
    assign lookup_accept_o = s_q.lk.accept;
    assign lookup_chan_o = s_q.lk.chan;
    assign tx_start_o = s_q.tx_start;
    assign rx_permit_o = s_q.rx_permit;
    assign tx_hdp_o = s_q.tx_hdp;
    assign rx_hdp_o = s_q.rx_hdp;

endmodule

// ===== sim/rxar_regs_asserts.sv
`timescale 1ns/10ps
module rxar_chk #(parameter int CHANS = rxar_pkg::CHANS) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Lookup and DMA side
    input wire logic lookup_req_i,
    input wire logic lookup_valid_o,
    input wire logic lookup_hit_o,
    input wire logic lookup_accept_o,
    input wire logic [2:0] lookup_chan_o,
    input wire logic [CHANS-1:0] tx_start_o,
    input wire logic [CHANS-1:0] rx_permit_o,
    input wire logic [CHANS-1:0][31:0] tx_hdp_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Request present last cycle, taken or not
    logic w_q, r_q;
    logic [7:0] a_q;
    logic [31:0] d_q;
    // Remember the last bus request
    always_ff @(posedge clk_i) begin
        w_q <= wb_cyc_i && wb_stb_i && wb_we_i;
        r_q <= wb_cyc_i && wb_stb_i && !wb_we_i;
        a_q <= wb_adr_i;
        d_q <= wb_dat_i;
    end
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    property p_ack; s_take |=> (wb_ack_o || wb_err_o); endproperty
    property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
    property p_txs; tx_start_o != '0 |-> w_q && a_q[7:5] == 3'h2; endproperty
    property p_rxp; rx_permit_o != '0 |-> w_q && a_q[7:5] == 3'h3; endproperty
    property p_txv; tx_start_o[0] |-> tx_hdp_o[0] == d_q; endproperty
    property p_lkv; lookup_req_i |=> lookup_valid_o; endproperty
    property p_lkc; !lookup_accept_o |-> lookup_chan_o == 3'h0; endproperty
    property p_acc; lookup_accept_o |-> lookup_hit_o; endproperty
    property p_idx; wb_ack_o && r_q && a_q == 8'h08 |-> wb_dat_o[31:5] == 27'h0; endproperty
    a_ack: assert property (p_ack) else $error("bus request not answered");
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    a_txs: assert property (p_txs) else $error("tx start without pointer write");
    a_rxp: assert property (p_rxp) else $error("rx permit without pointer write");
    a_txv: assert property (p_txv) else $error("tx pointer not loaded");
    a_lkv: assert property (p_lkv) else $error("lookup result late");
    a_lkc: assert property (p_lkc) else $error("channel given on rejected frame");
    a_acc: assert property (p_acc) else $error("accept without hit");
    a_idx: assert property (p_idx) else $error("index reserved bits set");
endmodule
bind rxar_regs rxar_chk #(.CHANS(CHANS)) u_chk (.*);

// ===== sim/tb_rx_addr_ram_and_dma_head_ptrs.sv
`timescale 1ns/10ps
module tb_rx_addr_ram_and_dma_head_ptrs;
    // Design ports
    logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00, ad, tx_start_o, rx_permit_o;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, h, l;
    logic wb_ack_o, wb_err_o, er, lookup_req_i = 1'h0, lookup_valid_o, lookup_hit_o;
    logic lookup_accept_o;
    logic [47:0] lookup_addr_i = 48'h0;
    logic [2:0] lookup_chan_o;
    logic [7:0] tx_hdp_clr_i = 8'h00, rx_hdp_clr_i = 8'h00;
    logic [7:0][31:0] tx_hdp_o, rx_hdp_o;
    logic [15:0] st;
    int bad_count = 0, num_checks = 0, seed = 32'h1a76, i, c;
    rxar_regs DUT (.*);
    // Clock
    initial forever #2.5 clk_i = ~clk_i;
    // Compare and count
    task chk(input logic [47:0] s, input logic [47:0] e);
        num_checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task end_sim;
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One Wishbone classic cycle, waits for ack or err
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, w, a, d, s};
        // Answer sampled at the edge itself, request released right after it
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 20);
        if (n >= 20) begin
            bad_count++;
            end_sim;
        end else begin
            rd = wb_dat_o;
            er = wb_err_o;
            st = {rx_permit_o, tx_start_o};
            {wb_cyc_i, wb_stb_i} <= 2'h0;
        end
    endtask
    // Filter lookup, result settled on return
    task lk(input logic [47:0] a);
        @(posedge clk_i);
        lookup_req_i <= 1'h1;
        lookup_addr_i <= a;
        @(posedge clk_i);
        lookup_req_i <= 1'h0;
        #1;
    endtask
    // Entry load: index, high, low
    task ld(input logic [31:0] k, input logic [31:0] hh, input logic [31:0] ll);
        wb(1'h1, 8'h08, k, 4'hF);
        wb(1'h1, 8'h04, hh, 4'hF);
        wb(1'h1, 8'h00, ll, 4'hF);
    endtask
    // Frame address from high and low register images
    function automatic logic [47:0] mk(input logic [31:0] hh, input logic [31:0] ll);
        return {hh[7:0], hh[15:8], hh[23:16], hh[31:24], ll[7:0], ll[15:8]};
    endfunction
    // Watchdog
    initial begin
        #100000;
        bad_count++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        for (c = 0; c < 16; c++) begin
            ad = 8'h40 + 8'(4 * c);
            h = $random(seed) | 32'h1;
            wb(1'h0, ad, 32'h0, 4'hF);
            chk(rd, 48'h0);
            wb(1'h1, ad, 32'h0, 4'hF);
            wb(1'h1, ad, h, 4'hF);
            chk(st, 16'h1 << c);
            chk(c < 8 ? tx_hdp_o[c] : rx_hdp_o[c - 8], h);
            wb(1'h0, ad, 32'h0, 4'hF);
            chk(rd, h);
        end
        @(posedge clk_i);
        tx_hdp_clr_i <= 8'h01;
        rx_hdp_clr_i <= 8'h80;
        @(posedge clk_i);
        tx_hdp_clr_i <= 8'h00;
        rx_hdp_clr_i <= 8'h00;
        wb(1'h0, 8'h0C, 32'h0, 4'hF);
        chk(rd, 32'h007F00FE);
        wb(1'h0, 8'hF0, 32'h0, 4'hF);
        chk(er, 1'h1);
        for (i = 0; i < 32; i++) ld(i, 32'h0, 32'h0);
        lk(48'h0);
        chk({lookup_valid_o, lookup_hit_o}, 2'h2);
        repeat (6) begin
            i = $random(seed) & 31;
            h = $random(seed);
            l = $random(seed) | 32'h00180000;
            ld(i, h, l);
            wb(1'h0, 8'h00, 32'h0, 4'hF);
            chk(rd, l & 32'h001FFFFF);
            wb(1'h0, 8'h04, 32'h0, 4'hF);
            chk(rd, h);
            wb(1'h1, 8'h08, 32'h1F, 4'hE);
            wb(1'h0, 8'h08, 32'h0, 4'hF);
            chk(rd, i);
            lk(mk(h, l));
            chk({lookup_hit_o, lookup_accept_o, lookup_chan_o}, {2'h3, l[18:16]});
            wb(1'h1, 8'h04, ~h, 4'hF);
            lk(mk(h, l));
            chk({lookup_hit_o, lookup_accept_o, lookup_chan_o}, {2'h3, l[18:16]});
            wb(1'h1, 8'h00, l & 32'hFFF7FFFF, 4'hF);
            lk(mk(~h, l));
            chk({lookup_hit_o, lookup_accept_o, lookup_chan_o}, 5'h10);
            lk(mk(h, l));
            chk(lookup_hit_o, 1'h0);
            ld((i + 1) & 31, ~h, l);
            lk(mk(~h, l));
            chk({lookup_hit_o, lookup_accept_o, lookup_chan_o}, 5'h10);
        end
        end_sim;
    end
endmodule
